// [pin_mux_map.svh]
// Register offsets, field positions and reset values of the pin mux.
// Assumes inclusion by bare name from files in the same folder.
`ifndef PIN_MUX_MAP_SVH
`define PIN_MUX_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PORT_E_LOW_SEL_OFS     4'h0
`define PORT_E_LINE4_SEL_OFS   4'h1
`define PORT_F_LOW_SEL_OFS     4'h2
`define PORT_F_HIGH_SEL_OFS    4'h3
`define TIMER_CLK_SRC_SEL_OFS  4'h4
`define SERIAL_IRQ_SRC_SEL_OFS 4'h5

// ----------------------------------------------------------------
// Field positions and masks
// ----------------------------------------------------------------
`define FIELD0_LSB             0
`define FIELD1_LSB             2
`define FIELD2_LSB             4
`define FIELD3_LSB             6
`define LINE4_SEL_MASK         8'h03
`define SEVEN_BIT_MASK         8'h7f
`define SEL_RESET              8'h00
`define READ_UNMAPPED          8'h00

`endif

// [pin_mux_pkg.sv]
// Types shared by the pin mux files.
// Assumes pin_mux_map.svh supplies the numeric constants.
package pin_mux_pkg;

  typedef enum logic [1:0]
  {
    CODE_IO0 = 2'b00,
    CODE_IO1 = 2'b01,
    CODE_ALT = 2'b10,
    CODE_SPC = 2'b11
  } sel_code_type;

  typedef struct packed
  {
    logic [7:0] e_low;
    logic [7:0] e_line4;
    logic [7:0] f_low;
    logic [7:0] f_high;
    logic [7:0] tmr_src;
    logic [7:0] ser_src;
  } sel_regs_type;

  typedef struct packed
  {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_type;

endpackage : pin_mux_pkg

// [sel_reg_file.sv]
// Holds the six select registers and answers the register port.
// Assumes one clock; reads answer in the following cycle.
`timescale 1ns/1ps
`include "pin_mux_map.svh"
module sel_reg_file
(
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire pin_mux_pkg::bus_req_type  req,
  output logic [7:0]                     rdata_reg,
  output pin_mux_pkg::sel_regs_type      regs_reg
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire logic [7:0] wmask;
  wire logic [7:0] rd_next;

  // Unimplemented bits are masked on write so they always read zero.
  assign wmask = (req.addr == `PORT_E_LINE4_SEL_OFS) ? `LINE4_SEL_MASK :
                 (req.addr == `TIMER_CLK_SRC_SEL_OFS ||
                  req.addr == `SERIAL_IRQ_SRC_SEL_OFS) ? `SEVEN_BIT_MASK :
                 8'hff;

  assign rd_next =
    (req.addr == `PORT_E_LOW_SEL_OFS)     ? regs_reg.e_low   :
    (req.addr == `PORT_E_LINE4_SEL_OFS)   ? regs_reg.e_line4 :
    (req.addr == `PORT_F_LOW_SEL_OFS)     ? regs_reg.f_low   :
    (req.addr == `PORT_F_HIGH_SEL_OFS)    ? regs_reg.f_high  :
    (req.addr == `TIMER_CLK_SRC_SEL_OFS)  ? regs_reg.tmr_src :
    (req.addr == `SERIAL_IRQ_SRC_SEL_OFS) ? regs_reg.ser_src :
    `READ_UNMAPPED;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      regs_reg  <= '0;
      rdata_reg <= `SEL_RESET;
    end
    else
    begin
      if (req.rd)
        rdata_reg <= rd_next;
      if (req.wr)
        unique case (req.addr)
          `PORT_E_LOW_SEL_OFS:     regs_reg.e_low   <= req.wdata & wmask;
          `PORT_E_LINE4_SEL_OFS:   regs_reg.e_line4 <= req.wdata & wmask;
          `PORT_F_LOW_SEL_OFS:     regs_reg.f_low   <= req.wdata & wmask;
          `PORT_F_HIGH_SEL_OFS:    regs_reg.f_high  <= req.wdata & wmask;
          `TIMER_CLK_SRC_SEL_OFS:  regs_reg.tmr_src <= req.wdata & wmask;
          `SERIAL_IRQ_SRC_SEL_OFS: regs_reg.ser_src <= req.wdata & wmask;
          default:                 ;
        endcase
    end
  end

endmodule : sel_reg_file

// [in_src_sel.sv]
// Picks each peripheral input from one of two candidate pins.
// Assumes pin levels are synchronous and the select bits registered.
`timescale 1ns/1ps
module in_src_sel
(
  input  wire logic [7:0] tmr_src,
  input  wire logic [7:0] ser_src,
  input  wire logic [1:0] cand_tmr [7],
  input  wire logic [1:0] cand_ser [7],
  output logic      [6:0] tmr_in,
  output logic      [6:0] ser_in
);

  // ----------------------------------------------------------------
  // Two-way selection
  // ----------------------------------------------------------------
  function automatic logic pick(input logic s, input logic [1:0] c);
    pick = s ? c[1] : c[0];
  endfunction : pick

  for (genvar i = 0; i < 7; i++)
  begin : g_sel
    assign tmr_in[i] = pick(tmr_src[i], cand_tmr[i]);
    assign ser_in[i] = pick(ser_src[i], cand_ser[i]);
  end

endmodule : in_src_sel

// [port_e_f_pin_function_mux.sv]
// Pin-function multiplexer for port E lines 0, 1, 4 and port F lines 0-7,
// with the two-way input source selectors for timers, serial and irqs.
// Assumes synchronous pin inputs, one clock CLK and async reset RST_N.
//
// Summary of operation
// - PE1 codes: io, io, timer0 out, spi data
// - PE0 codes: io with timer0 clock, 11 spi select
// - Line4 select bits 7..2 read zero
// - PE4: io for 00-10, io supply for 11
// - PF3: io, io, serial clock, lcd common3
// - PF2: io, io, serial data in, lcd common2
// - PF1: io, io, serial data out, lcd common1
// - PF0: io, io, serial select, lcd common0
// - PF7: io, uart1 tx, timer2 out, comp+
// - PF6: io with timer2 clock, uart1 rx, comp-
// - PF5: io, io, periodic timer0 out, crystal in
// - PF4: io with periodic clock0, 11 crystal out
// - Timer clock selectors pick one of two pins
// - Serial select source: PA1 or alternate pin
// - Serial data source: PA4 or PF2
// - Serial clock source: PA5 or PF3
// - Irq2 PA4/PD0, irq3 PA5/PC7
// - Irq1 PA3/PA7, irq0 PA1/PA6
`timescale 1ns/1ps
`include "pin_mux_map.svh"
module port_e_f_pin_function_mux
(
  input  wire logic       CLK,
  input  wire logic       RST_N,
  input  wire logic [3:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  // Pin levels seen at the pads.
  input  wire logic [7:0] PA_IN,
  input  wire logic [7:0] PB_IN,
  input  wire logic [7:0] PC_IN,
  input  wire logic [7:0] PD_IN,
  input  wire logic [4:0] PE_IN,
  input  wire logic [7:0] PF_IN,
  // Port data latch and output enable (low drives) from the port block.
  input  wire logic [4:0] PE_IO_OUT,
  input  wire logic [4:0] PE_IO_OE_N,
  input  wire logic [7:0] PF_IO_OUT,
  input  wire logic [7:0] PF_IO_OE_N,
  // Peripheral outputs that may claim a pin.
  input  wire logic       STD_TIMER_OUT0,
  input  wire logic       STD_TIMER_OUT2,
  input  wire logic       PERIODIC_TIMER_OUT0,
  input  wire logic       AUX_SPI_DATA_OUT,
  input  wire logic       SERIAL_SDO,
  input  wire logic       SERIAL_SCK_OUT,
  input  wire logic       SERIAL_SCK_OE_N,
  input  wire logic       SERIAL_SDA_OUT,
  input  wire logic       SERIAL_SDA_OE_N,
  input  wire logic       UART1_TRANSMIT,
  input  wire logic [3:0] LCD_COMMON,
  // Pad drive for the lines handled here.
  output logic      [4:0] PE_OUT,
  output logic      [4:0] PE_OE_N,
  output logic      [7:0] PF_OUT,
  output logic      [7:0] PF_OE_N,
  // Analog / special pad routing, high when connected.
  output logic            IO_SUPPLY_INPUT_EN,
  output logic            COMPARATOR0_POS_IN_EN,
  output logic            COMPARATOR0_NEG_IN_EN,
  output logic            CRYSTAL_IN_EN,
  output logic            CRYSTAL_OUT_EN,
  output logic      [3:0] LCD_COMMON_EN,
  // Inputs delivered to peripherals.
  output logic      [2:0] STD_TIMER_CLK_IN,
  output logic      [3:0] PERIODIC_TIMER_CLK_IN,
  output logic            SERIAL_IF_SELECT_N,
  output logic            SERIAL_DATA_IN,
  output logic            SERIAL_CLOCK_IN,
  output logic            AUX_SPI_SELECT,
  output logic            UART1_RECEIVE,
  output logic      [3:0] EXT_IRQ
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  pin_mux_pkg::bus_req_type  req;
  pin_mux_pkg::sel_regs_type regs;
  logic [7:0]                rdata_q;

  assign req.addr  = ADDR;
  assign req.wdata = WDATA;
  assign req.wr    = WR;
  assign req.rd    = RD;
  assign RDATA     = rdata_q;

  sel_reg_file u_regs
  (
    .clk       (CLK),
    .rst_n     (RST_N),
    .req       (req),
    .rdata_reg (rdata_q),
    .regs_reg  (regs)
  );

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  function automatic pin_mux_pkg::sel_code_type fld(input logic [7:0] r,
                                                    input int lsb);
    fld = pin_mux_pkg::sel_code_type'(r[lsb +: 2]);
  endfunction : fld

  pin_mux_pkg::sel_code_type pe0_c, pe1_c, pe4_c;
  pin_mux_pkg::sel_code_type pf0_c, pf1_c, pf2_c, pf3_c;
  pin_mux_pkg::sel_code_type pf4_c, pf5_c, pf6_c, pf7_c;

  assign pe0_c = fld(regs.e_low, `FIELD0_LSB);
  assign pe1_c = fld(regs.e_low, `FIELD1_LSB);
  assign pe4_c = fld(regs.e_line4, `FIELD0_LSB);
  assign pf0_c = fld(regs.f_low, `FIELD0_LSB);
  assign pf1_c = fld(regs.f_low, `FIELD1_LSB);
  assign pf2_c = fld(regs.f_low, `FIELD2_LSB);
  assign pf3_c = fld(regs.f_low, `FIELD3_LSB);
  assign pf4_c = fld(regs.f_high, `FIELD0_LSB);
  assign pf5_c = fld(regs.f_high, `FIELD1_LSB);
  assign pf6_c = fld(regs.f_high, `FIELD2_LSB);
  assign pf7_c = fld(regs.f_high, `FIELD3_LSB);

  // Port E lines 2 and 3 belong to fields not handled here.
  wire logic pe1_tmr  = (pe1_c == pin_mux_pkg::CODE_ALT);
  wire logic pe1_spi  = (pe1_c == pin_mux_pkg::CODE_SPC);
  wire logic pe0_spi  = (pe0_c == pin_mux_pkg::CODE_SPC);
  wire logic pe4_vdd  = (pe4_c == pin_mux_pkg::CODE_SPC);
  wire logic pf3_ser  = (pf3_c == pin_mux_pkg::CODE_ALT);
  wire logic pf2_ser  = (pf2_c == pin_mux_pkg::CODE_ALT);
  wire logic pf1_ser  = (pf1_c == pin_mux_pkg::CODE_ALT);
  wire logic pf0_ser  = (pf0_c == pin_mux_pkg::CODE_ALT);
  wire logic pf7_tx   = (pf7_c == pin_mux_pkg::CODE_IO1);
  wire logic pf7_tmr  = (pf7_c == pin_mux_pkg::CODE_ALT);
  wire logic pf7_cmp  = (pf7_c == pin_mux_pkg::CODE_SPC);
  wire logic pf6_rx   = (pf6_c == pin_mux_pkg::CODE_ALT);
  wire logic pf6_cmp  = (pf6_c == pin_mux_pkg::CODE_SPC);
  // Code 01 of line 5 is taken as plain port I/O.
  wire logic pf5_tmr  = (pf5_c == pin_mux_pkg::CODE_ALT);
  wire logic pf5_xt   = (pf5_c == pin_mux_pkg::CODE_SPC);
  wire logic pf4_xt   = (pf4_c == pin_mux_pkg::CODE_SPC);

  wire logic [3:0] lcd_sel;
  assign lcd_sel = {pf3_c == pin_mux_pkg::CODE_SPC,
                    pf2_c == pin_mux_pkg::CODE_SPC,
                    pf1_c == pin_mux_pkg::CODE_SPC,
                    pf0_c == pin_mux_pkg::CODE_SPC};

  // ----------------------------------------------------------------
  // Pad drive
  // ----------------------------------------------------------------
  // Analog functions and input-only roles release the pad (enable high); PF2/PF3 serial roles follow the serial enables; LCD common and spi data drive it.
  logic [4:0] pe_out_next, pe_oe_n_next;
  logic [7:0] pf_out_next, pf_oe_n_next;

  assign pe_out_next[0] = PE_IO_OUT[0];
  assign pe_oe_n_next[0] = pe0_spi ? 1'b1 : PE_IO_OE_N[0];
  assign pe_out_next[1] = pe1_tmr ? STD_TIMER_OUT0 :
                          pe1_spi ? AUX_SPI_DATA_OUT :
                          PE_IO_OUT[1];
  assign pe_oe_n_next[1] = (pe1_tmr | pe1_spi) ? 1'b0 : PE_IO_OE_N[1];
  assign pe_out_next[3:2] = PE_IO_OUT[3:2];
  assign pe_oe_n_next[3:2] = PE_IO_OE_N[3:2];
  assign pe_out_next[4] = PE_IO_OUT[4];
  assign pe_oe_n_next[4] = pe4_vdd ? 1'b1 : PE_IO_OE_N[4];

  assign pf_out_next[0] = lcd_sel[0] ? LCD_COMMON[0] : PF_IO_OUT[0];
  assign pf_oe_n_next[0] = pf0_ser ? 1'b1 :
                           lcd_sel[0] ? 1'b0 : PF_IO_OE_N[0];
  assign pf_out_next[1] = pf1_ser ? SERIAL_SDO :
                          lcd_sel[1] ? LCD_COMMON[1] : PF_IO_OUT[1];
  assign pf_oe_n_next[1] = (pf1_ser | lcd_sel[1]) ? 1'b0 :
                           PF_IO_OE_N[1];
  assign pf_out_next[2] = pf2_ser ? SERIAL_SDA_OUT :
                          lcd_sel[2] ? LCD_COMMON[2] : PF_IO_OUT[2];
  assign pf_oe_n_next[2] = pf2_ser ? SERIAL_SDA_OE_N :
                           lcd_sel[2] ? 1'b0 : PF_IO_OE_N[2];
  assign pf_out_next[3] = pf3_ser ? SERIAL_SCK_OUT :
                          lcd_sel[3] ? LCD_COMMON[3] : PF_IO_OUT[3];
  assign pf_oe_n_next[3] = pf3_ser ? SERIAL_SCK_OE_N :
                           lcd_sel[3] ? 1'b0 : PF_IO_OE_N[3];
  assign pf_out_next[4] = PF_IO_OUT[4];
  assign pf_oe_n_next[4] = pf4_xt ? 1'b1 : PF_IO_OE_N[4];
  assign pf_out_next[5] = pf5_tmr ? PERIODIC_TIMER_OUT0 : PF_IO_OUT[5];
  assign pf_oe_n_next[5] = pf5_tmr ? 1'b0 :
                           pf5_xt ? 1'b1 : PF_IO_OE_N[5];
  assign pf_out_next[6] = PF_IO_OUT[6];
  assign pf_oe_n_next[6] = (pf6_rx | pf6_cmp) ? 1'b1 :
                           PF_IO_OE_N[6];
  assign pf_out_next[7] = pf7_tx ? UART1_TRANSMIT :
                          pf7_tmr ? STD_TIMER_OUT2 : PF_IO_OUT[7];
  assign pf_oe_n_next[7] = (pf7_tx | pf7_tmr) ? 1'b0 :
                           pf7_cmp ? 1'b1 : PF_IO_OE_N[7];

  // ----------------------------------------------------------------
  // Input source selection
  // ----------------------------------------------------------------
  // A function input whose pin is claimed by another role sees its idle level (high for the
  // selects and uart1 rx, low otherwise), so a stray toggle cannot clock or trigger the peripheral.
  logic [1:0] cand_tmr [7];
  logic [1:0] cand_ser [7];
  logic [6:0] tmr_in, ser_in;

  wire logic pe0_io = ~pe0_spi;
  wire logic pf2_rt = pf2_ser;
  wire logic pf3_rt = pf3_ser;
  wire logic pf6_io = ~(pf6_rx | pf6_cmp);
  wire logic pf4_io = ~pf4_xt;

  assign cand_tmr[0] = {PE_IN[0] & pe0_io, PC_IN[7]};
  assign cand_tmr[1] = {PB_IN[7], PD_IN[1]};
  assign cand_tmr[2] = {PB_IN[0], PF_IN[6] & pf6_io};
  assign cand_tmr[3] = {PF_IN[4] & pf4_io, PC_IN[3]};
  assign cand_tmr[4] = {PE_IN[2], PC_IN[5]};
  assign cand_tmr[5] = {PB_IN[2], PD_IN[3]};
  assign cand_tmr[6] = {PB_IN[1], PD_IN[5]};
  assign cand_ser[0] = {PA_IN[6], PA_IN[1]};
  assign cand_ser[1] = {PA_IN[7], PA_IN[3]};
  assign cand_ser[2] = {PD_IN[0], PA_IN[4]};
  assign cand_ser[3] = {PC_IN[7], PA_IN[5]};
  assign cand_ser[4] = {PF_IN[3] & pf3_rt, PA_IN[5]};
  assign cand_ser[5] = {PF_IN[2] & pf2_rt, PA_IN[4]};
  // The alternate select pin is port F line 0 in its serial role.
  assign cand_ser[6] = {pf0_ser ? PF_IN[0] : 1'b1, PA_IN[1]};

  in_src_sel u_src
  (
    .tmr_src  (regs.tmr_src),
    .ser_src  (regs.ser_src),
    .cand_tmr (cand_tmr),
    .cand_ser (cand_ser),
    .tmr_in   (tmr_in),
    .ser_in   (ser_in)
  );

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  // Registering adds one cycle, so a new select code acts next cycle.
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      PE_OUT  <= '0;
      PE_OE_N <= '1;
      PF_OUT  <= '0;
      PF_OE_N <= '1;
      {IO_SUPPLY_INPUT_EN, COMPARATOR0_POS_IN_EN} <= 2'h0;
      {COMPARATOR0_NEG_IN_EN, CRYSTAL_IN_EN, CRYSTAL_OUT_EN} <= 3'h0;
      LCD_COMMON_EN         <= 4'h0;
      STD_TIMER_CLK_IN      <= 3'h0;
      PERIODIC_TIMER_CLK_IN <= 4'h0;
      SERIAL_IF_SELECT_N    <= 1'b1;
      SERIAL_DATA_IN        <= 1'b0;
      SERIAL_CLOCK_IN       <= 1'b0;
      AUX_SPI_SELECT        <= 1'b1;
      UART1_RECEIVE         <= 1'b1;
      EXT_IRQ               <= 4'h0;
    end
    else
    begin
      PE_OUT  <= pe_out_next;
      PE_OE_N <= pe_oe_n_next;
      PF_OUT  <= pf_out_next;
      PF_OE_N <= pf_oe_n_next;
      IO_SUPPLY_INPUT_EN    <= pe4_vdd;
      COMPARATOR0_POS_IN_EN <= pf7_cmp;
      COMPARATOR0_NEG_IN_EN <= pf6_cmp;
      CRYSTAL_IN_EN         <= pf5_xt;
      CRYSTAL_OUT_EN        <= pf4_xt;
      LCD_COMMON_EN         <= lcd_sel;
      STD_TIMER_CLK_IN      <= tmr_in[2:0];
      PERIODIC_TIMER_CLK_IN <= tmr_in[6:3];
      EXT_IRQ               <= ser_in[3:0];
      SERIAL_CLOCK_IN       <= ser_in[4];
      SERIAL_DATA_IN        <= ser_in[5];
      SERIAL_IF_SELECT_N    <= ser_in[6];
      AUX_SPI_SELECT        <= pe0_spi ? PE_IN[0] : 1'b1;
      UART1_RECEIVE         <= pf6_rx ? PF_IN[6] : 1'b1;
    end
  end

endmodule : port_e_f_pin_function_mux

// [pin_mux_sva.sv]
// Checker for the pin mux: register port answers and routing relations.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`include "pin_mux_map.svh"
module pin_mux_sva
(
  input wire logic       CLK,
  input wire logic       RST_N,
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic       WR,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  input wire logic [7:0] PA_IN,
  input wire logic [7:0] PB_IN,
  input wire logic [7:0] PC_IN,
  input wire logic [7:0] PD_IN,
  input wire logic [4:0] PE_OUT,
  input wire logic [4:0] PE_OE_N,
  input wire logic       STD_TIMER_OUT0,
  input wire logic [3:0] LCD_COMMON_EN,
  input wire logic [2:0] STD_TIMER_CLK_IN,
  input wire logic [3:0] EXT_IRQ
);
  // ------
  // Shadow copies of the select registers
  // ------
  logic [7:0] e_sh;
  logic [7:0] f_sh;
  logic [7:0] t_sh;
  logic [7:0] s_sh;
  logic [3:0] irq_exp;
  logic       std_timer_clk_in1_exp;

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      e_sh <= 8'h00;
      f_sh <= 8'h00;
      t_sh <= 8'h00;
      s_sh <= 8'h00;
    end
    else if (WR)
    begin
      if (ADDR == `PORT_E_LOW_SEL_OFS) e_sh <= WDATA;
      if (ADDR == `PORT_F_LOW_SEL_OFS) f_sh <= WDATA;
      if (ADDR == `TIMER_CLK_SRC_SEL_OFS) t_sh <= WDATA;
      if (ADDR == `SERIAL_IRQ_SRC_SEL_OFS) s_sh <= WDATA;
    end
  end

  assign irq_exp   = {s_sh[3] ? PC_IN[7] : PA_IN[5],
                      s_sh[2] ? PD_IN[0] : PA_IN[4],
                      s_sh[1] ? PA_IN[7] : PA_IN[3],
                      s_sh[0] ? PA_IN[6] : PA_IN[1]};
  assign std_timer_clk_in1_exp = t_sh[1] ? PB_IN[7] : PD_IN[1];

  // ------
  // Assertions
  // ------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  chk_rdata_hold: assert property (
    $past(RST_N) && !$past(RD) |-> $stable(RDATA))
    else $error("read data changed without a read");
  chk_line4_zero: assert property (
    RD && ADDR == `PORT_E_LINE4_SEL_OFS |=> RDATA[7:2] == 6'h00)
    else $error("line 4 select upper bits not zero");
  chk_src_bit7: assert property (
    RD && (ADDR == 4'h4 || ADDR == 4'h5) |=> !RDATA[7])
    else $error("source select bit 7 not zero");
  chk_unmapped_read: assert property (
    RD && ADDR > 4'h5 |=> RDATA == 8'h00)
    else $error("unmapped read not zero");
  chk_write_readback: assert property (
    WR && ADDR == 4'h2 ##1 RD && ADDR == 4'h2 |=> RDATA == $past(WDATA, 2))
    else $error("port F low select readback wrong");
  chk_lcd_common: assert property (
    f_sh[1:0] == 2'b11 |=> LCD_COMMON_EN[0])
    else $error("lcd common 0 not given the pad");
  chk_pe1_timer: assert property (
    e_sh[3:2] == 2'b10 |=> !PE_OE_N[1] && PE_OUT[1] == $past(STD_TIMER_OUT0))
    else $error("timer output 0 not on line 1");
  chk_irq_route: assert property (
    $past(RST_N) |-> EXT_IRQ == $past(irq_exp))
    else $error("external irq source wrong");
  chk_std_timer_clk_in1_route: assert property (
    $past(RST_N) |-> STD_TIMER_CLK_IN[1] == $past(std_timer_clk_in1_exp))
    else $error("timer 1 clock source wrong");
endmodule : pin_mux_sva

bind port_e_f_pin_function_mux pin_mux_sva i_sva (.*);

// [pin_periph_model.sv]
// Pads and peripheral outputs around the pin mux, driven from one pattern.
// Assumes the bench changes pat right after a rising clock edge.
`timescale 1ns/1ps
module pin_periph_model
(
  input  wire logic       CLK,
  input  wire logic [7:0] pat,
  output logic      [7:0] PA_IN,
  output logic      [7:0] PB_IN,
  output logic      [7:0] PC_IN,
  output logic      [7:0] PD_IN,
  output logic      [4:0] PE_IN,
  output logic      [7:0] PF_IN,
  output logic      [4:0] PE_IO_OUT,
  output logic      [4:0] PE_IO_OE_N,
  output logic      [7:0] PF_IO_OUT,
  output logic      [7:0] PF_IO_OE_N,
  output logic            STD_TIMER_OUT0,
  output logic            STD_TIMER_OUT2,
  output logic            PERIODIC_TIMER_OUT0,
  output logic            AUX_SPI_DATA_OUT,
  output logic            SERIAL_SDO,
  output logic            SERIAL_SCK_OUT,
  output logic            SERIAL_SCK_OE_N,
  output logic            SERIAL_SDA_OUT,
  output logic            SERIAL_SDA_OE_N,
  output logic            UART1_TRANSMIT,
  output logic      [3:0] LCD_COMMON
);
  logic [7:0] p = 8'h00;
  logic [7:0] q;

  always_ff @(posedge CLK) p <= pat;

  // Sources see several views of the pattern (p, ~p, swapped nibbles, p xor 5a), so a pin routed
  // from a source with another view shows up as a wrong level.
  assign q                   = {p[3:0], p[7:4]};
  assign PA_IN               = p;
  assign PB_IN               = ~p;
  assign PC_IN               = q;
  assign PD_IN               = p ^ 8'h5a;
  assign PE_IN               = p[4:0];
  assign PF_IN               = ~q;
  assign PE_IO_OUT           = ~p[4:0];
  assign PE_IO_OE_N          = p[4:0];
  assign PF_IO_OUT           = q;
  assign PF_IO_OE_N          = p;
  assign STD_TIMER_OUT0      = p[0];
  assign STD_TIMER_OUT2      = p[1];
  assign PERIODIC_TIMER_OUT0 = ~p[2];
  assign AUX_SPI_DATA_OUT    = p[3];
  assign SERIAL_SDO          = ~p[4];
  assign SERIAL_SCK_OUT      = p[5];
  assign SERIAL_SCK_OE_N     = p[6];
  assign SERIAL_SDA_OUT      = p[7];
  assign SERIAL_SDA_OE_N     = ~p[6];
  assign UART1_TRANSMIT      = ~p[1];
  assign LCD_COMMON          = p[7:4];
endmodule : pin_periph_model

// [port_e_f_pin_function_mux_tb_top.sv]
// Self-checking bench for the pin mux with the pad and peripheral model.
// Assumes outputs settle two edges after a write or a pattern change.
`timescale 1ns/1ps
`include "pin_mux_map.svh"
module port_e_f_pin_function_mux_tb_top;
  logic       CLK   = 1'b0;
  logic       RST_N = 1'b0;
  logic [3:0] ADDR  = 4'h0;
  logic [7:0] WDATA = 8'h00;
  logic       WR    = 1'b0;
  logic       RD    = 1'b0;
  logic [7:0] pat   = 8'ha6;
  logic [7:0] RDATA, PA_IN, PB_IN, PC_IN, PD_IN, PF_IN;
  logic [7:0] PF_IO_OUT, PF_IO_OE_N, PF_OUT, PF_OE_N;
  logic [4:0] PE_IN, PE_IO_OUT, PE_IO_OE_N, PE_OUT, PE_OE_N;
  logic [3:0] LCD_COMMON, LCD_COMMON_EN, PERIODIC_TIMER_CLK_IN, EXT_IRQ;
  logic [2:0] STD_TIMER_CLK_IN;
  logic STD_TIMER_OUT0, STD_TIMER_OUT2, PERIODIC_TIMER_OUT0, AUX_SPI_DATA_OUT;
  logic SERIAL_SDO, SERIAL_SCK_OUT, SERIAL_SCK_OE_N, SERIAL_SDA_OUT;
  logic SERIAL_SDA_OE_N, UART1_TRANSMIT, IO_SUPPLY_INPUT_EN, UART1_RECEIVE;
  logic COMPARATOR0_POS_IN_EN, COMPARATOR0_NEG_IN_EN, CRYSTAL_IN_EN;
  logic CRYSTAL_OUT_EN, SERIAL_IF_SELECT_N, SERIAL_DATA_IN, SERIAL_CLOCK_IN;
  logic AUX_SPI_SELECT;
  int   mismatches = 0;
  int   checks     = 0;
  int   cycles     = 0;

  always #10 CLK = ~CLK;

  port_e_f_pin_function_mux i_dut (.*);
  pin_periph_model          i_peer (.*);

  // ------
  // Bus and compare helpers
  // ------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge CLK);
    ADDR  <= a;
    WDATA <= d;
    WR    <= 1'b1;
    RD    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge CLK);
    ADDR <= a;
    WR   <= 1'b0;
    RD   <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1;
    chk(RDATA, e);
  endtask : rd

  // Lets the write land in the register and the output flops, and gives
  // the pad model four edges to present the new pattern.
  task automatic settle(input logic [7:0] p);
    @(posedge CLK);
    WR  <= 1'b0;
    RD  <= 1'b0;
    pat <= p;
    repeat (4) @(posedge CLK);
    #1;
  endtask : settle

  // ------
  // Scenarios
  // ------
  task automatic t_reset;
    @(posedge CLK);
    RST_N <= 1'b0;
    @(posedge CLK);
    RST_N <= 1'b1;
    for (int a = 0; a < 6; a++)
      rd(4'(a), 8'h00);
    settle(8'h3c);
    chk(PF_OE_N, PF_IO_OE_N);
  endtask : t_reset

  task automatic t_masks;
    logic [7:0] mask [7] = '{8'hff, 8'h03, 8'hff, 8'hff, 8'h7f, 8'h7f, 8'h00};
    for (int a = 0; a < 7; a++)
    begin
      wr(4'(a), 8'hff);
      rd(4'(a), mask[a]);
    end
  endtask : t_masks

  task automatic t_pf_low(input logic [7:0] p);
    for (int c = 0; c < 4; c++)
    begin
      wr(`PORT_F_LOW_SEL_OFS, {4{c[1:0]}});
      settle(p);
      chk(LCD_COMMON_EN, (c == 3) ? 8'h0f : 8'h00);
      if (c < 2)
      begin
        chk(PF_OUT[3:0], PF_IO_OUT[3:0]);
        chk(PF_OE_N[3:0], PF_IO_OE_N[3:0]);
      end
      if (c == 2)
      begin
        chk(PF_OUT[1], SERIAL_SDO);
        chk(PF_OE_N[1:0], 2'b01);
      end
      if (c == 3)
        chk({PF_OUT[3:0], PF_OE_N[3:0]}, {LCD_COMMON, 4'h0});
    end
  endtask : t_pf_low

  task automatic t_pf_high(input logic [7:0] p);
    // Timer 2 clock must come from its default pin for the checks below.
    wr(`TIMER_CLK_SRC_SEL_OFS, 8'h00);
    for (int c = 0; c < 4; c++)
    begin
      wr(`PORT_F_HIGH_SEL_OFS, {4{c[1:0]}});
      settle(p);
      chk({COMPARATOR0_POS_IN_EN, COMPARATOR0_NEG_IN_EN, CRYSTAL_IN_EN,
           CRYSTAL_OUT_EN}, (c == 3) ? 8'h0f : 8'h00);
      if (c == 0)
        chk({PF_OUT[7:4], UART1_RECEIVE}, {PF_IO_OUT[7:4], 1'b1});
      if (c == 1)
        chk({PF_OUT[7], PF_OUT[5]},
            {UART1_TRANSMIT, PF_IO_OUT[5]});
      if (c < 2)
        chk(STD_TIMER_CLK_IN[2], PF_IN[6]);
      if (c == 2)
        chk({PF_OUT[7], PF_OUT[5], UART1_RECEIVE},
            {STD_TIMER_OUT2, PERIODIC_TIMER_OUT0, PF_IN[6]});
    end
  endtask : t_pf_high

  task automatic t_pe(input logic [7:0] p);
    wr(`TIMER_CLK_SRC_SEL_OFS, 8'h01);
    for (int c = 0; c < 4; c++)
    begin
      wr(`PORT_E_LOW_SEL_OFS, {4'h0, c[1:0], c[1:0]});
      wr(`PORT_E_LINE4_SEL_OFS, {6'h00, c[1:0]});
      settle(p);
      chk(IO_SUPPLY_INPUT_EN, c == 3);
      chk(STD_TIMER_CLK_IN[0], (c == 3) ? 1'b0 : PE_IN[0]);
      chk(AUX_SPI_SELECT, (c == 3) ? PE_IN[0] : 1'b1);
      chk(PE_OUT[1], (c < 2) ? PE_IO_OUT[1] : (c == 2) ? STD_TIMER_OUT0 :
          AUX_SPI_DATA_OUT);
      chk(PE_OE_N, (c < 2) ? PE_IO_OE_N :
          (c == 2) ? {PE_IO_OE_N[4:2], 1'b0, PE_IO_OE_N[0]} :
          {1'b1, PE_IO_OE_N[3:2], 2'b01});
    end
  endtask : t_pe

  task automatic t_src(input logic [7:0] p);
    for (int s = 0; s < 2; s++)
    begin
      wr(`SERIAL_IRQ_SRC_SEL_OFS, s ? 8'h0f : 8'h00);
      wr(`TIMER_CLK_SRC_SEL_OFS, s ? 8'h7e : 8'h00);
      settle(p);
      chk(EXT_IRQ, s ? {PC_IN[7], PD_IN[0], PA_IN[7], PA_IN[6]} :
          {PA_IN[5], PA_IN[4], PA_IN[3], PA_IN[1]});
      chk(STD_TIMER_CLK_IN[1], s ? PB_IN[7] : PD_IN[1]);
      chk(PERIODIC_TIMER_CLK_IN[3:2], s ? {PB_IN[1], PB_IN[2]} :
          {PD_IN[5], PD_IN[3]});
    end
    wr(`PORT_F_LOW_SEL_OFS, 8'ha2);
    wr(`SERIAL_IRQ_SRC_SEL_OFS, 8'h70);
    settle(p);
    chk({SERIAL_IF_SELECT_N, SERIAL_DATA_IN, SERIAL_CLOCK_IN},
        {PF_IN[0], PF_IN[2], PF_IN[3]});
    wr(`SERIAL_IRQ_SRC_SEL_OFS, 8'h00);
    settle(p);
    chk({SERIAL_IF_SELECT_N, SERIAL_DATA_IN, SERIAL_CLOCK_IN},
        {PA_IN[1], PA_IN[4], PA_IN[5]});
  endtask : t_src

  task automatic report_and_stop;
    $display("TB: %0d checks, %0d mismatches", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : report_and_stop

  // The whole run needs well under a thousand cycles.
  always @(posedge CLK)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      report_and_stop();
    end
  end

  initial
  begin
    repeat (2) @(posedge CLK);
    RST_N <= 1'b1;
    t_reset();
    t_masks();
    t_reset();
    for (int i = 0; i < 2; i++)
    begin
      t_pf_low(i ? 8'h59 : 8'ha6);
      t_pf_high(i ? 8'h59 : 8'ha6);
      t_pe(i ? 8'h59 : 8'ha6);
      t_src(i ? 8'h59 : 8'ha6);
    end
    report_and_stop();
  end
endmodule : port_e_f_pin_function_mux_tb_top
